/* add_immediate_decode_exec.v */
// Decode and execution of the four add-immediate encodings, behind an APB slave
`timescale 1ns/1ps
`default_nettype none
`include "add_imm_regs.vh"

// Contract
// - Narrow three-field form: 3-bit dest, 3-bit source, 3-bit immediate zero-extended.
// - Narrow shared form: one register is dest and operand, 8-bit immediate zero-extended.
// - Wide flag form expands the 12-bit immediate as modified constant; flags when S set.
// - Wide flag form: dest 1111 with S is compare-negative; operand 1101 is SP add.
// - Wide flag form: dest 13, dest 15 without S, or operand 15, is unspecified.
// - Wide plain form never sets flags; zero-extends the 12-bit immediate.
// - Wide plain form: operand 1111 is PC-relative address; 1101 is SP add.
// - Wide plain form: dest 13 or 15 is unspecified; operand unconstrained.
// - Immediate ranges are 0-7, 0-255 and 0-4095 for the zero-extended forms.
// - On condition pass add immediate to operand, carry-in zero, write dest.
// - Flag update sets N from bit 31, Z on zero, C carry, V overflow.
// - Condition fail leaves destination and all flags untouched.
// - Narrow forms set flags only outside a conditional block.
module add_immediate_decode_exec
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr
);

   reg  [31:0] instr_word;
   reg         go;
   reg  [1:0]  ctrl;
   reg  [3:0]  program_status_flags;
   reg  [7:0]  status;
   reg  [31:0] result;
   reg  [31:0] gpr [0:15];

   wire        access = psel & penable & pready;
   wire        wr_en = access & pwrite;
   wire        aligned = (paddr[1:0] == 2'h0);
   wire        is_gpr = aligned && (paddr >= `GPR_BASE_OFFSET) && (paddr <= `GPR_LAST_OFFSET);
   wire [3:0]  gpr_idx = paddr[5:2];
   wire        sel_instr = (paddr == `INSTR_OFFSET);
   wire        sel_ctrl = (paddr == `CTRL_OFFSET);
   wire        sel_flags = (paddr == `FLAGS_OFFSET);
   // Writes land only at the edge that completes the access phase
   wire        wr_instr = wr_en && sel_instr;
   wire        wr_ctrl = wr_en && sel_ctrl;
   wire        wr_flags = wr_en && sel_flags;
   wire        wr_gpr = wr_en && is_gpr;

   // First halfword sits in the upper half, second in the lower half
   wire [15:0] hw1 = instr_word[31:16];
   wire [15:0] hw2 = instr_word[15:0];

   // Field extraction
   wire [2:0]  three_bit_immediate = hw1[8:6];
   wire [2:0]  narrow_three_src = hw1[5:3];
   wire [2:0]  narrow_three_dest = hw1[2:0];
   wire [2:0]  narrow_shared_reg = hw1[10:8];
   wire [7:0]  narrow_eight_bit_imm = hw1[7:0];
   wire        top_imm_bit = hw1[10];
   wire [3:0]  first_operand_field = hw1[3:0];
   wire [2:0]  wide_three_bit_imm = hw2[14:12];
   wire [3:0]  wide_dest = hw2[11:8];
   wire [7:0]  eight_bit_immediate = hw2[7:0];
   wire [11:0] twelve_bit_immediate = {top_imm_bit, wide_three_bit_imm, eight_bit_immediate};
   wire        set_bit = hw1[4];
   wire        dest_reserved = (wide_dest == `REG_SP) || (wide_dest == `REG_PC);

   wire is_narrow_three = (hw1[15:9] == `OP_NARROW_THREE);
   wire is_narrow_shared = (hw1[15:11] == `OP_NARROW_SHARED);
   wire is_wide_flags = (hw1[15:11] == `OP_WIDE_PREFIX) && !hw1[9]
                        && (hw1[8:5] == `OP_WIDE_FLAGS_MID) && !hw2[15];
   wire is_wide_plain = (hw1[15:11] == `OP_WIDE_PREFIX)
                        && (hw1[9:4] == `OP_WIDE_PLAIN_MID) && !hw2[15];

   // Modified constant expansion; rotated form is widened to double length to rotate
   wire [1:0]  replicate_sel = twelve_bit_immediate[9:8];
   wire [4:0]  rotate_amount = twelve_bit_immediate[11:7];
   wire [7:0]  unrotated = {1'h1, twelve_bit_immediate[6:0]};
   reg  [31:0] modified_constant_expand;
   reg         expand_odd;
   reg  [63:0] rot_pair;
   always @*
   begin
      expand_odd = 1'h0;
      rot_pair = 64'h0;
      modified_constant_expand = 32'h0;
      if (twelve_bit_immediate[11:10] == 2'h0)
      begin
         case (replicate_sel)
            2'h0: modified_constant_expand = {24'h0, eight_bit_immediate};
            2'h1: modified_constant_expand = {8'h0, eight_bit_immediate,
                                              8'h0, eight_bit_immediate};
            2'h2: modified_constant_expand = {eight_bit_immediate, 8'h0,
                                              eight_bit_immediate, 8'h0};
            default: modified_constant_expand = {4{eight_bit_immediate}};
         endcase
         // A zero byte with a replicating pattern has no defined value
         expand_odd = (replicate_sel != 2'h0) && (eight_bit_immediate == 8'h0);
      end
      else
      begin
         rot_pair = {24'h0, unrotated, 24'h0, unrotated} >> rotate_amount;
         modified_constant_expand = rot_pair[31:0];
      end
   end

   // Form decode
   reg  [2:0]  form;
   reg  [3:0]  dest;
   reg  [3:0]  src;
   reg  [31:0] imm32;
   reg         set_flags;
   reg         redirected;
   reg         unspecified_behaviour;
   always @*
   begin
      form = `FORM_NONE;
      dest = 4'h0;
      src = 4'h0;
      imm32 = 32'h0;
      set_flags = 1'b0;
      redirected = 1'b0;
      unspecified_behaviour = 1'b0;
      if (is_narrow_three)
      begin
         form = `FORM_NARROW_THREE;
         dest = {1'h0, narrow_three_dest};
         src = {1'h0, narrow_three_src};
         imm32 = {29'h0, three_bit_immediate};
         set_flags = !ctrl[`CTRL_IN_BLOCK_BIT];
      end
      else if (is_narrow_shared)
      begin
         form = `FORM_NARROW_SHARED;
         dest = {1'h0, narrow_shared_reg};
         src = {1'h0, narrow_shared_reg};
         imm32 = {24'h0, narrow_eight_bit_imm};
         set_flags = !ctrl[`CTRL_IN_BLOCK_BIT];
      end
      else if (is_wide_flags)
      begin
         form = `FORM_WIDE_FLAGS;
         dest = wide_dest;
         src = first_operand_field;
         imm32 = modified_constant_expand;
         set_flags = set_bit;
         redirected = ((wide_dest == `REG_PC) && set_bit)
                      || (first_operand_field == `REG_SP);
         unspecified_behaviour = !redirected && (dest_reserved
                                 || (first_operand_field == `REG_PC) || expand_odd);
      end
      else if (is_wide_plain)
      begin
         form = `FORM_WIDE_PLAIN;
         dest = wide_dest;
         src = first_operand_field;
         imm32 = {20'h0, twelve_bit_immediate};
         set_flags = 1'b0;
         redirected = (first_operand_field == `REG_PC)
                      || (first_operand_field == `REG_SP);
         unspecified_behaviour = !redirected && dest_reserved;
      end
   end

   // Adder with carry-in of zero
   wire [32:0] adder_with_carry_in = {1'b0, gpr[src]} + {1'b0, imm32};
   wire [31:0] sum = adder_with_carry_in[31:0];
   wire        ovf = (gpr[src][31] == imm32[31]) && (sum[31] != gpr[src][31]);

   // Other encodings and unspecified ones are left alone so nothing is corrupted
   wire        condition_check = ctrl[`CTRL_COND_PASS_BIT];
   wire        executes = go && condition_check && (form != `FORM_NONE)
                          && !redirected && !unspecified_behaviour;

   // Status word and flag image that the execute cycle stores
   reg  [7:0]  next_status;
   reg  [3:0]  next_flags;
   always @*
   begin
      next_status = 8'h0;
      next_status[2:0] = form;
      next_status[3] = unspecified_behaviour;
      next_status[4] = redirected;
      next_status[5] = executes;
      next_status[6] = executes && set_flags;
      next_status[7] = (form == `FORM_NONE);
      next_flags = program_status_flags;
      if (set_flags)
      begin
         next_flags[`FLAG_N_BIT] = sum[31];
         next_flags[`FLAG_Z_BIT] = (sum == 32'h0);
         next_flags[`FLAG_C_BIT] = adder_with_carry_in[32];
         next_flags[`FLAG_V_BIT] = ovf;
      end
   end

   // Bus-side control: the launch strobe follows an instruction write by one cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         instr_word <= 32'h0;
         go <= 1'h0;
         ctrl <= `CTRL_RESET;
      end
      else
      begin
         go <= wr_instr;
         if (wr_instr)
            instr_word <= pwdata;
         if (wr_ctrl)
            ctrl <= pwdata[1:0];
      end
   end

   // Register file; an execution lands in the cycle after an access completes, while pready is low, so it never meets a bus write
   integer k;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (k = 0; k < 16; k = k + 1)
            gpr[k] <= 32'h0;
      end
      else
      begin
         if (wr_gpr)
            gpr[gpr_idx] <= pwdata;
         if (executes)
            gpr[dest] <= sum;
      end
   end

   // Execution results; the execute cycle wins over a software flag write
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         program_status_flags <= `FLAGS_RESET;
         status <= 8'h0;
         result <= 32'h0;
      end
      else
      begin
         if (go)
            status <= next_status;
         if (executes)
         begin
            result <= sum;
            program_status_flags <= next_flags;
         end
         else if (wr_flags)
            program_status_flags <= pwdata[3:0];
      end
   end

   // APB answer: one wait state, read data registered
   reg  [31:0] next_prdata;
   reg         next_err;
   always @*
   begin
      next_prdata = 32'h0;
      next_err = 1'b0;
      if (is_gpr)
         next_prdata = gpr[gpr_idx];
      else
      begin
         case (paddr)
            `INSTR_OFFSET:  next_prdata = instr_word;
            `CTRL_OFFSET:   next_prdata = {30'h0, ctrl};
            `FLAGS_OFFSET:  next_prdata = {28'h0, program_status_flags};
            `STATUS_OFFSET: next_prdata = {24'h0, status};
            `RESULT_OFFSET: next_prdata = result;
            default:        next_err = 1'b1;
         endcase
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && next_err;
         if (psel && penable && !pready && !pwrite)
            prdata <= next_prdata;
      end
   end

endmodule

`default_nettype wire

/* add_imm_regs.vh */
// Register offsets, field positions and opcode patterns of the add-immediate unit
`ifndef ADD_IMM_REGS_VH
`define ADD_IMM_REGS_VH

`define INSTR_OFFSET        12'h000
`define CTRL_OFFSET         12'h004
`define FLAGS_OFFSET        12'h008
`define STATUS_OFFSET       12'h00c
`define RESULT_OFFSET       12'h010
`define GPR_BASE_OFFSET     12'h040
`define GPR_LAST_OFFSET     12'h07c

`define CTRL_COND_PASS_BIT  0
`define CTRL_IN_BLOCK_BIT   1
`define CTRL_RESET          2'h1

`define FLAG_N_BIT          3
`define FLAG_Z_BIT          2
`define FLAG_C_BIT          1
`define FLAG_V_BIT          0
`define FLAGS_RESET         4'h0

`define FORM_NONE           3'h0
`define FORM_NARROW_THREE   3'h1
`define FORM_NARROW_SHARED  3'h2
`define FORM_WIDE_FLAGS     3'h3
`define FORM_WIDE_PLAIN     3'h4

`define OP_NARROW_THREE     7'h0e
`define OP_NARROW_SHARED    5'h06
`define OP_WIDE_PREFIX      5'h1e
`define OP_WIDE_FLAGS_MID   4'h8
`define OP_WIDE_PLAIN_MID   6'h20

`define REG_SP              4'hd
`define REG_PC              4'hf

`endif

/* dummy_end.v */
// Intentionally empty
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* add_imm_bus_monitor.sv */
// Bus timing checks for the add-immediate unit
`timescale 1ns/1ps
`default_nettype none
module add_imm_bus_monitor
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire mapped = paddr[1:0] == 2'h0 && (paddr <= 12'h010 || paddr[11:6] == 6'h01);
   property p_rdy_acc; pready |-> psel && penable; endproperty
   a_rdy_acc: assert property (p_rdy_acc) else $error("ready outside access");
   property p_rdy_lat; psel && $rose(penable) |=> pready; endproperty
   a_rdy_lat: assert property (p_rdy_lat) else $error("ready late");
   property p_rdy_one; pready |=> !pready; endproperty
   a_rdy_one: assert property (p_rdy_one) else $error("ready too long");
   property p_err_rdy; pslverr |-> pready; endproperty
   a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
   property p_map_ok; pready && mapped |-> !pslverr; endproperty
   a_map_ok: assert property (p_map_ok) else $error("error on register");
   property p_unm_err; pready && !mapped |-> pslverr; endproperty
   a_unm_err: assert property (p_unm_err) else $error("no error on hole");
   property p_unm_zero; pready && !pwrite && !mapped |-> prdata == 32'h0; endproperty
   a_unm_zero: assert property (p_unm_zero) else $error("hole data");
   property p_rd_hold; $changed(prdata) |-> pready && !pwrite; endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   c_write: cover property (pready && pwrite);
   c_read: cover property (pready && !pwrite);
   c_error: cover property (pslverr);
endmodule
bind add_immediate_decode_exec add_imm_bus_monitor i_mon (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

/* apb_host.sv */
// APB master standing in for the fetch stage that feeds the unit
`timescale 1ns/1ps
`default_nettype none
module apb_host
(
   input  wire logic        pclk,
   output var  logic        psel = 1'b0,
   output var  logic        penable = 1'b0,
   output var  logic        pwrite = 1'b0,
   output var  logic [11:0] paddr = 12'h0,
   output var  logic [31:0] pwdata = 32'h0,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // A slave that never answers gives ok low after 50 edges
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e, output logic ok);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      q = prdata;
      e = pslverr;
      ok = pready === 1'b1;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines show the inverse, so a stale value never looks valid
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule
`default_nettype wire

/* add_immediate_decode_exec_test.sv */
// Self-checking bench for the add-immediate unit
`timescale 1ns/1ps
`default_nettype none
module add_immediate_decode_exec_test;
   typedef struct packed {logic [31:0] ins; logic [1:0] c; logic [3:0] n;
      logic [31:0] v; logic [3:0] d; logic [31:0] x; logic [3:0] f; logic [7:0] s;} row_t;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   int          err_total = 0;
   int          tests_run = 0;
   int          i;
   // Operand, condition and block state per row; dest preset to 5a, flags to a
   row_t        rows [14] = '{
      '{32'h1dca0000, 2'h1, 4'h1, 32'hfffffff9, 4'h2, 32'h0, 4'h6, 8'h61},
      '{32'h1dca0000, 2'h3, 4'h1, 32'hfffffff9, 4'h2, 32'h0, 4'ha, 8'h21},
      '{32'h33ff0000, 2'h1, 4'h3, 32'h7fffff01, 4'h3, 32'h80000000, 4'h9, 8'h62},
      '{32'hf1144500, 2'h1, 4'h4, 32'h80000000, 4'h5, 32'h0, 4'h7, 8'h63},
      '{32'hf1044500, 2'h1, 4'h4, 32'h80000000, 4'h5, 32'h0, 4'ha, 8'h23},
      '{32'hf60677ff, 2'h1, 4'h6, 32'hfffff001, 4'h7, 32'h0, 4'ha, 8'h24},
      '{32'hf1144500, 2'h0, 4'h4, 32'h1, 4'h5, 32'h5a, 4'ha, 8'h03},
      '{32'hf1144f00, 2'h1, 4'h4, 32'h1, 4'hf, 32'h5a, 4'ha, 8'h13},
      '{32'hf60d77ff, 2'h1, 4'hd, 32'h1, 4'h7, 32'h5a, 4'ha, 8'h14},
      '{32'hf6067dff, 2'h1, 4'h6, 32'h1, 4'hd, 32'h5a, 4'ha, 8'h0c},
      '{32'hf10f4500, 2'h1, 4'hf, 32'h1, 4'h5, 32'h5a, 4'ha, 8'h0b},
      '{32'hf11415ab, 2'h1, 4'h4, 32'h1, 4'h5, 32'h00ab00ac, 4'h0, 8'h63},
      '{32'hf1142580, 2'h1, 4'h4, 32'h80008000, 4'h5, 32'h00010000, 4'h3, 8'h63},
      '{32'hf1143500, 2'h1, 4'h4, 32'h1, 4'h5, 32'h5a, 4'ha, 8'h0b}};
   apb_host i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   add_immediate_decode_exec i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   task automatic chk(input logic c, input string m);
      tests_run++;
      if (!c)
      begin
         $display("mismatch at %0t: %s", $time, m);
         err_total++;
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // For reads d is the expected data
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic xe);
      logic [31:0] q;
      logic        e;
      logic        ok;
      i_host.xfer(w, a, d, q, e, ok);
      if (!ok)
      begin
         chk(1'b0, "no ready");
         wrap_up();
      end
      else
         chk(e === xe && (w || q === d), "bus answer");
   endtask
   task automatic chk_reset();
      bus(1'b0, 12'h004, 32'h1, 1'b0);
      bus(1'b0, 12'h008, 32'h0, 1'b0);
      bus(1'b0, 12'h054, 32'h0, 1'b0);
   endtask
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial
   begin
      presetn = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      chk_reset();
      $display("reset values done");
      for (i = 0; i < 14; i++)
      begin
         bus(1'b1, 12'h008, 32'ha, 1'b0);
         bus(1'b1, 12'h040 + {rows[i].d, 2'h0}, 32'h5a, 1'b0);
         bus(1'b1, 12'h040 + {rows[i].n, 2'h0}, rows[i].v, 1'b0);
         bus(1'b1, 12'h004, {30'h0, rows[i].c}, 1'b0);
         bus(1'b1, 12'h000, rows[i].ins, 1'b0);
         bus(1'b0, 12'h040 + {rows[i].d, 2'h0}, rows[i].x, 1'b0);
         bus(1'b0, 12'h008, {28'h0, rows[i].f}, 1'b0);
         bus(1'b0, 12'h00c, {24'h0, rows[i].s}, 1'b0);
         if (rows[i].s[5])
            bus(1'b0, 12'h010, rows[i].x, 1'b0);
         $display("row %0d done", i);
      end
      bus(1'b0, 12'h00c, 32'hb, 1'b0);
      bus(1'b1, 12'h000, 32'h0, 1'b0);
      bus(1'b0, 12'h00c, 32'h80, 1'b0);
      $display("foreign encoding done");
      bus(1'b1, 12'h020, 32'h1, 1'b1);
      bus(1'b0, 12'h020, 32'h0, 1'b1);
      bus(1'b1, 12'h041, 32'h1, 1'b1);
      bus(1'b0, 12'h041, 32'h0, 1'b1);
      $display("unmapped access done");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk_reset();
      $display("second reset done");
      wrap_up();
   end
endmodule
`default_nettype wire
